/* rtl/spcr_pkg.sv */
package spcr_pkg;
  // Register byte offsets
  localparam logic [6:0] OFS_GC0  = 7'h00;
  localparam logic [6:0] OFS_GC1  = 7'h04;
  localparam logic [6:0] OFS_INT  = 7'h08;
  localparam logic [6:0] OFS_LVL  = 7'h0C;
  localparam logic [6:0] OFS_FLG  = 7'h10;
  localparam logic [6:0] OFS_PC0  = 7'h14;
  localparam logic [6:0] OFS_PC2  = 7'h1C;
  localparam logic [6:0] OFS_DAT  = 7'h3C;
  localparam logic [6:0] OFS_BUF  = 7'h40;
  localparam logic [6:0] OFS_EMU  = 7'h44;
  localparam logic [6:0] OFS_DLY  = 7'h48;
  localparam logic [6:0] OFS_DEF  = 7'h4C;
  localparam logic [6:0] OFS_FMT  = 7'h50;
  localparam logic [6:0] OFS_VEC0 = 7'h60;
  localparam logic [6:0] OFS_VEC1 = 7'h64;

  // Field positions
  localparam int B_RESET  = 0;
  localparam int B_ROLE   = 0;
  localparam int B_CLKSEL = 1;
  localparam int B_PDN    = 8;
  localparam int B_LOOP   = 16;
  localparam int B_EN     = 24;
  localparam int B_DMA    = 16;
  localparam int B_TX     = 9;
  localparam int B_RX     = 8;
  localparam int B_OVR    = 6;
  localparam int B_BIT    = 4;
  localparam int B_PAR    = 2;
  localparam int B_EMPTY  = 31;
  localparam int B_BOVR   = 30;
  localparam int B_BBIT   = 28;
  localparam int B_BPAR   = 24;
  localparam int B_PAREN  = 22;
  localparam int PIN_MI   = 11;
  localparam int PIN_MO   = 10;
  localparam int PIN_SCLK = 9;

  // Writable bits and reset value
  localparam logic [31:0] GC1_MASK = 32'h0101_0103;
  localparam logic [31:0] INT_MASK = 32'h0001_0354;
  localparam logic [31:0] LVL_MASK = 32'h0000_0354;
  localparam logic [31:0] PC0_MASK = 32'h0000_0E03;
  localparam logic [31:0] DAT_MASK = 32'h0003_FFFF;
  localparam logic [31:0] FMT_MASK = 32'h0040_0000;
  localparam logic [31:0] REG_RST  = 32'h0000_0000;

  // Interrupt sources, index order of the flag vector
  localparam int NSRC  = 5;
  localparam int F_PAR = 0;
  localparam int F_BIT = 1;
  localparam int F_OVR = 2;
  localparam int F_RX  = 3;
  localparam int F_TX  = 4;
  localparam logic [4:0] W1C_SRC = 5'h0F;

  // Word size and serial clock timing
  localparam int CHAR_BITS   = 8;
  localparam int CLK_NS      = 10;
  localparam int SCLK_HALF_NS = 40;
  localparam int HALF_CYC    = SCLK_HALF_NS / CLK_NS;

  typedef enum logic {PH_IDLE, PH_SHIFT} spcr_phase_t;

  function automatic logic [4:0] to_src(input logic [31:0] r);
    return {r[B_TX], r[B_RX], r[B_OVR], r[B_BIT], r[B_PAR]};
  endfunction

  function automatic logic [31:0] from_src(input logic [4:0] v);
    logic [31:0] r;
    r = REG_RST;
    r[B_TX]  = v[F_TX];
    r[B_RX]  = v[F_RX];
    r[B_OVR] = v[F_OVR];
    r[B_BIT] = v[F_BIT];
    r[B_PAR] = v[F_PAR];
    return r;
  endfunction
endpackage

/* rtl/spcr_irq_if.sv */
`timescale 1ns/1ps
interface spcr_irq_if;
  import spcr_pkg::*;
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] enables;
  logic [NSRC-1:0] line_sel;
  logic            line0;
  logic            line1;
  logic [4:0]      vec0;
  logic [4:0]      vec1;
  modport regs   (output flags, enables, line_sel, input line0, line1, vec0, vec1);
  modport router (input flags, enables, line_sel, output line0, line1, vec0, vec1);
endinterface

/* rtl/spcr_sync.sv */
`timescale 1ns/1ps
module spcr_sync #(
  parameter int W = 5
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spcr_sync_t;

  spcr_sync_t s_reg;
  spcr_sync_t s_next;

  // Two stages; only the second stage is visible to the block
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;
endmodule

/* rtl/spcr_irq_route.sv */
`timescale 1ns/1ps
module spcr_irq_route
  import spcr_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  spcr_irq_if.router irq
);
  typedef struct packed {
    logic       line0;
    logic       line1;
    logic [4:0] vec0;
    logic [4:0] vec1;
  } spcr_route_t;

  spcr_route_t s_reg;
  spcr_route_t s_next;
  logic [NSRC-1:0] on0;
  logic [NSRC-1:0] on1;

  // Enabled flags split by line select
  assign on0 = irq.flags & irq.enables & ~irq.line_sel;  // RL13 RL14 RL15 RL16
  assign on1 = irq.flags & irq.enables & irq.line_sel;   // RL16

  // Lines and vectors; lowest source index wins the vector
  always_comb begin
    s_next       = s_reg;
    s_next.line0 = |on0;  // RL24
    s_next.line1 = |on1;  // RL24
    s_next.vec0  = 5'h00;
    s_next.vec1  = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (on0[i]) begin
        s_next.vec0 = 5'(i + 1);
      end
      if (on1[i]) begin
        s_next.vec1 = 5'(i + 1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign irq.line0 = s_reg.line0;
  assign irq.line1 = s_reg.line1;
  assign irq.vec0  = s_reg.vec0;
  assign irq.vec1  = s_reg.vec1;
endmodule

/* rtl/spcr_regs.sv */
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
// What this block does
// RL1: Control-0 bit 0 low holds the whole port in reset; high releases it.
// RL2: Software sets transfer enable last, after all other configuration.
// RL3: Transfer enable low clears shifters, word field, flags, buffers; marks empty.
// RL4: Loop-back routes the serial output straight back to the receiver.
// RL5: In loop-back the clock pin idles low and slave data pin floats.
// RL6: Software picks master with internal clock before loop-back, never mid-transfer.
// RL7: Power-down bit freezes the transfer engine; clear means active.
// RL8: Clock select bit picks internal clock and drives chip selects.
// RL9: Role bit sets which data pin is output and which input.
// RL10: Slave needs role and clock bits both clear; master needs role set.
// RL11: DMA request enable gates both DMA requests.
// RL12: Software readies DMA channels before enabling DMA requests.
// RL13: Transmit interrupt asserts whenever transmit-empty flag and its enable are set.
// RL14: Receive and overrun enables pass their flags to interrupts.
// RL15: Bit mismatch and parity enables pass their flags to interrupts.
// RL16: Line select bit routes each source to line zero or one.
// RL17: Transmit-empty flag sets whenever a word enters the shifter.
// RL18: Transmit-empty clears on a data write or transfer enable low.
// RL19: Software writes zero to reserved bits.
// RL20: Clearing receive flag discards the word; a held word then moves up.
// RL21: Overrun clears by writing one or reading a vector register.
// RL22: Own output pin sampled at receive point; mismatch sets bit mismatch flag.
// RL23: Parity fault sets on mismatch; clears by write-one or enable low.
// RL24: Each line is high while an enabled flag routed to it is set.
// RL25: Registers are 32-bit words; reserved bits read zero.
module spcr_regs
  import spcr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        master_out_pin_i,
  output logic             master_out_pin_o,
  output logic             master_out_pin_oe,
  input  wire logic        master_in_pin_i,
  output logic             master_in_pin_o,
  output logic             master_in_pin_oe,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  input  wire logic [1:0]  chip_select_pins_i,
  output logic      [1:0]  chip_select_pins_o,
  output logic      [1:0]  chip_select_pins_oe,
  output logic             dma_tx_req,
  output logic             dma_rx_req,
  output logic             irq_line_zero,
  output logic             irq_line_one
);
  typedef struct packed {
    logic               gc0;
    logic [31:0]        gc1;
    logic [31:0]        ien;
    logic [31:0]        lvl;
    logic [31:0]        pc0;
    logic [31:0]        dly;
    logic [31:0]        def;
    logic [31:0]        fmt;
    logic [31:0]        dat;
    logic [NSRC-1:0]    flg;
    logic [15:0]        tx_hold;
    logic               tx_hold_v;
    logic [CHAR_BITS:0] sh_tx;
    logic [CHAR_BITS:0] sh_rx;
    logic [3:0]         bits_left;
    logic [3:0]         div;
    logic               sclk_q;
    logic               tx_bit;
    logic               bit_err;
    logic               sclk_prev;
    spcr_phase_t        phase;
    logic [15:0]        rxb;
    logic [2:0]         rxb_st;
    logic               rxb_v;
    logic [15:0]        rxh;
    logic [2:0]         rxh_st;
    logic               rxh_v;
    logic [31:0]        rdata;
    logic               mo_o;
    logic               mo_oe;
    logic               mi_o;
    logic               mi_oe;
    logic               sclk_o;
    logic               sclk_oe;
    logic [1:0]         cs_o;
    logic [1:0]         cs_oe;
    logic               dma_tx;
    logic               dma_rx;
  } spcr_state_t;

  spcr_state_t s_reg;
  spcr_state_t s_next;
  logic [4:0]  pin_s;
  logic        mi_s;
  logic        mo_s;
  logic        sclk_s;
  logic        role;
  logic        clk_int;
  logic        loop;
  logic        par_en;
  logic        rx_pin;
  logic        own_pin;
  logic        tick;
  logic        lead;
  logic        trail;
  logic        run;
  logic [3:0]  nbits;
  logic [31:0] buf_img;
  logic [31:0] pin_img;

  spcr_irq_if irq ();

  // Pins come from another domain: two flops before any use
  spcr_sync #(.W(5)) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .d        ({master_in_pin_i, master_out_pin_i, serial_clock_pin_i, chip_select_pins_i}),
    .q        (pin_s)
  );

  spcr_irq_route u_route (
    .core_clk (core_clk),
    .resetn   (resetn),
    .irq      (irq)
  );

  assign mi_s   = pin_s[4];
  assign mo_s   = pin_s[3];
  assign sclk_s = pin_s[2];

  // Flag, enable and line vectors to the interrupt router
  assign irq.flags    = s_reg.flg;
  assign irq.enables  = to_src(s_reg.ien);
  assign irq.line_sel = to_src(s_reg.lvl);

  // Mode decode
  assign role    = s_reg.gc1[B_ROLE];
  assign clk_int = s_reg.gc1[B_ROLE] & s_reg.gc1[B_CLKSEL];  // RL8
  assign loop    = s_reg.gc1[B_LOOP];
  assign par_en  = s_reg.fmt[B_PAREN];
  assign nbits   = par_en ? 4'(CHAR_BITS + 1) : 4'(CHAR_BITS);
  assign run     = (s_reg.phase == PH_SHIFT) & ~s_reg.gc1[B_PDN];  // RL7

  // Receive source; loop-back takes the transmit bit directly
  assign rx_pin  = loop ? s_reg.tx_bit : (role ? mi_s : mo_s);  // RL4
  // Own transmit pin as seen outside (the transmit bit itself in loop-back), for the mismatch check
  assign own_pin = loop ? s_reg.tx_bit : (role ? mo_s : mi_s);

  // Serial clock edges: divider when internal, sampled pin otherwise
  assign tick  = (s_reg.div == 4'(HALF_CYC - 1));
  assign lead  = clk_int ? (tick & ~s_reg.sclk_q) : (sclk_s & ~s_reg.sclk_prev);
  assign trail = clk_int ? (tick & s_reg.sclk_q) : (~sclk_s & s_reg.sclk_prev);

  // Receive buffer image and pin readback image
  always_comb begin
    buf_img          = REG_RST;
    buf_img[15:0]    = s_reg.rxb;
    buf_img[B_EMPTY] = ~s_reg.rxb_v;
    buf_img[B_BOVR]  = s_reg.rxb_st[2];
    buf_img[B_BBIT]  = s_reg.rxb_st[1];
    buf_img[B_BPAR]  = s_reg.rxb_st[0];
    pin_img           = REG_RST;
    pin_img[PIN_MI]   = mi_s;
    pin_img[PIN_MO]   = mo_s;
    pin_img[PIN_SCLK] = sclk_s;
    pin_img[1:0]      = pin_s[1:0];
  end

  // Next state: bus clears first, then hardware sets, then forced resets
  always_comb begin
    logic             done;
    logic [15:0]      rw;
    logic             pbad;
    logic [31:0]      keep_rd;
    done    = 1'b0;
    rw      = 16'h0000;
    pbad    = 1'b0;
    keep_rd = REG_RST;
    s_next           = s_reg;
    s_next.rdata     = REG_RST;
    s_next.sclk_prev = sclk_s;

    if (reg_wr) begin
      case (reg_addr)
        OFS_GC0: s_next.gc0 = reg_wdata[B_RESET];
        OFS_GC1: s_next.gc1 = reg_wdata & GC1_MASK;
        OFS_INT: begin
          s_next.ien = reg_wdata & INT_MASK;
          // Disabling a source also drops its pending receive or overrun flag
          s_next.flg[F_RX]  = s_reg.flg[F_RX] & reg_wdata[B_RX];
          s_next.flg[F_OVR] = s_reg.flg[F_OVR] & reg_wdata[B_OVR];
        end
        OFS_LVL: s_next.lvl = reg_wdata & LVL_MASK;
        OFS_FLG: begin
          s_next.flg = s_next.flg & ~(to_src(reg_wdata) & W1C_SRC);  // RL21 RL23
          if (reg_wdata[B_RX] && s_reg.rxb_v) begin
            s_next.rxb      = s_reg.rxh;  // RL20
            s_next.rxb_st   = s_reg.rxh_st;
            s_next.rxb_v    = s_reg.rxh_v;
            s_next.flg[F_RX] = s_reg.rxh_v;
            s_next.rxh_v    = 1'b0;
          end
        end
        OFS_PC0: s_next.pc0 = reg_wdata & PC0_MASK;
        OFS_DAT: begin
          s_next.dat       = reg_wdata & DAT_MASK;
          s_next.tx_hold   = reg_wdata[15:0];
          s_next.tx_hold_v = 1'b1;
          s_next.flg[F_TX] = 1'b0;  // RL18
        end
        OFS_DLY: s_next.dly = reg_wdata;
        OFS_DEF: s_next.def = reg_wdata;
        OFS_FMT: s_next.fmt = reg_wdata & FMT_MASK;
        default: ;
      endcase
    end

    // Reads; unmapped offsets answer zero
    if (reg_rd) begin
      case (reg_addr)
        OFS_GC0: s_next.rdata = {31'h0000_0000, s_reg.gc0};  // RL25
        OFS_GC1: s_next.rdata = s_reg.gc1;
        OFS_INT: s_next.rdata = s_reg.ien;
        OFS_LVL: s_next.rdata = s_reg.lvl;
        OFS_FLG: s_next.rdata = from_src(s_reg.flg);
        OFS_PC0: s_next.rdata = s_reg.pc0;
        OFS_PC2: s_next.rdata = pin_img;
        OFS_DAT: s_next.rdata = s_reg.dat;
        OFS_BUF: begin
          s_next.rdata = buf_img;
          // Consuming read: the held word, if any, moves up
          s_next.rxb       = s_reg.rxh;
          s_next.rxb_st    = s_reg.rxh_st;
          s_next.rxb_v     = s_reg.rxh_v;
          s_next.flg[F_RX] = s_reg.rxh_v;
          s_next.rxh_v     = 1'b0;
        end
        OFS_EMU: s_next.rdata = buf_img;
        OFS_DLY: s_next.rdata = s_reg.dly;
        OFS_DEF: s_next.rdata = s_reg.def;
        OFS_FMT: s_next.rdata = s_reg.fmt;
        OFS_VEC0: begin
          s_next.rdata      = {26'h000_0000, irq.vec0, 1'b0};
          s_next.flg[F_OVR] = 1'b0;  // RL21
        end
        OFS_VEC1: begin
          s_next.rdata      = {26'h000_0000, irq.vec1, 1'b0};
          s_next.flg[F_OVR] = 1'b0;  // RL21
        end
        default: s_next.rdata = REG_RST;
      endcase
    end

    // Shift engine, held still while powered down
    if (run) begin  // RL7
      if (clk_int) begin
        s_next.div = tick ? 4'h0 : s_reg.div + 4'h1;
        if (tick) begin
          s_next.sclk_q = ~s_reg.sclk_q;
        end
      end
      if (lead) begin
        s_next.sh_rx     = {s_reg.sh_rx[CHAR_BITS-1:0], rx_pin};
        s_next.bits_left = s_reg.bits_left - 4'h1;
        if (own_pin != s_reg.tx_bit) begin
          s_next.bit_err = 1'b1;  // RL22
        end
        done = (s_reg.bits_left == 4'h1);
      end else if (trail && s_reg.bits_left == 4'h0) begin
        // Closing fall after the last rise, so the peer sees every rising edge
        s_next.phase = PH_IDLE;
      end else if (trail) begin
        s_next.tx_bit = s_reg.sh_tx[CHAR_BITS-1];
        s_next.sh_tx  = {s_reg.sh_tx[CHAR_BITS-1:0], 1'b0};
      end
    end

    // Word complete: store it, then raise the matching flags
    if (done) begin
      rw[CHAR_BITS-1:0] = par_en ? s_next.sh_rx[CHAR_BITS:1] : s_next.sh_rx[CHAR_BITS-1:0];
      pbad = par_en & (^s_next.sh_rx);
      if (s_next.bit_err) begin
        s_next.flg[F_BIT] = 1'b1;  // RL22
      end
      if (pbad) begin
        s_next.flg[F_PAR] = 1'b1;  // RL23
      end
      if (!s_next.rxb_v) begin
        s_next.rxb       = rw;
        s_next.rxb_st    = {1'b0, s_next.bit_err, pbad};
        s_next.rxb_v     = 1'b1;
        s_next.flg[F_RX] = 1'b1;  // RL14
      end else begin
        // Overrun always lands in the holding buffer
        if (s_next.rxh_v) begin
          s_next.flg[F_OVR] = 1'b1;  // RL14
        end
        s_next.rxh    = rw;
        s_next.rxh_st = {s_next.rxh_v, s_next.bit_err, pbad};
        s_next.rxh_v  = 1'b1;
      end
      s_next.bit_err = 1'b0;
    end

    // Move a pending word into the idle shifter; first bit goes out at once
    if (s_next.phase == PH_IDLE && s_next.tx_hold_v && s_reg.gc1[B_EN] && !s_reg.gc1[B_PDN]) begin
      s_next.sh_tx     = {s_next.tx_hold[CHAR_BITS-1:0], ^s_next.tx_hold[CHAR_BITS-1:0]};
      s_next.tx_bit    = s_next.tx_hold[CHAR_BITS-1];
      s_next.bits_left = nbits;
      s_next.tx_hold_v = 1'b0;
      s_next.phase     = PH_SHIFT;
      s_next.flg[F_TX] = 1'b1;  // RL17
    end

    // Transfer enable low forces the data path back to its defaults
    if (!s_next.gc1[B_EN]) begin
      s_next.flg       = '0;  // RL3 RL18 RL23
      s_next.dat[15:0] = 16'h0000;
      s_next.sh_tx     = '0;
      s_next.sh_rx     = '0;
      s_next.tx_hold_v = 1'b0;
      s_next.rxb       = 16'h0000;
      s_next.rxb_st    = 3'h0;
      s_next.rxb_v     = 1'b0;
      s_next.rxh       = 16'h0000;
      s_next.rxh_st    = 3'h0;
      s_next.rxh_v     = 1'b0;
      s_next.phase     = PH_IDLE;
      s_next.tx_bit    = 1'b0;
      s_next.bit_err   = 1'b0;
      s_next.sclk_q    = 1'b0;
      s_next.div       = 4'h0;
    end

    // Module reset: everything but read data returns to zero; pin and DMA drivers are set below from s_reg
    if (!s_next.gc0) begin
      keep_rd      = s_next.rdata;
      s_next       = '0;  // RL1
      s_next.rdata = keep_rd;
    end

    // Pin drivers, registered so outputs leave flops
    s_next.mo_oe   = role & s_reg.pc0[PIN_MO];  // RL9
    s_next.mo_o    = ~loop & s_reg.tx_bit;
    s_next.mi_oe   = ~role & s_reg.pc0[PIN_MI] & ~loop;  // RL5 RL9
    s_next.mi_o    = s_reg.tx_bit;
    s_next.sclk_oe = clk_int & s_reg.pc0[PIN_SCLK];  // RL8
    s_next.sclk_o  = ~loop & s_reg.sclk_q;  // RL5
    s_next.cs_oe   = {2{s_reg.gc1[B_CLKSEL]}} & s_reg.pc0[1:0];  // RL8
    s_next.cs_o    = (s_reg.phase == PH_SHIFT) ? (s_reg.def[1:0] & ~s_reg.dat[17:16])
                                               : s_reg.def[1:0];
    s_next.dma_tx  = s_reg.gc1[B_EN] & s_reg.ien[B_DMA] & s_reg.flg[F_TX];  // RL11
    s_next.dma_rx  = s_reg.gc1[B_EN] & s_reg.ien[B_DMA] & s_reg.flg[F_RX];  // RL11
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata           = s_reg.rdata;
  assign master_out_pin_o    = s_reg.mo_o;
  assign master_out_pin_oe   = s_reg.mo_oe;
  assign master_in_pin_o     = s_reg.mi_o;
  assign master_in_pin_oe    = s_reg.mi_oe;
  assign serial_clock_pin_o  = s_reg.sclk_o;
  assign serial_clock_pin_oe = s_reg.sclk_oe;
  assign chip_select_pins_o  = s_reg.cs_o;
  assign chip_select_pins_oe = s_reg.cs_oe;
  assign dma_tx_req          = s_reg.dma_tx;
  assign dma_rx_req          = s_reg.dma_rx;
  assign irq_line_zero       = irq.line0;
  assign irq_line_one        = irq.line1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_soft_reset_hold: assert property (!s_reg.gc0 |-> s_reg.gc1 == REG_RST && s_reg.flg == '0)  // RL1
    else $error("module reset did not hold control state");
  a_enable_clears: assert property (!s_reg.gc1[B_EN] |-> s_reg.flg == '0 && !s_reg.rxb_v)  // RL3
    else $error("disabled port kept flags or data");
  a_loop_quiet: assert property (s_reg.gc1[B_LOOP] |=> !master_in_pin_oe && !serial_clock_pin_o)  // RL5
    else $error("loop-back disturbed external pins");
  a_role_dir: assert property (master_out_pin_oe |-> $past(s_reg.gc1[B_ROLE]))  // RL9
    else $error("data pin driven against role");
  a_pdn_freeze: assert property (s_reg.gc1[B_PDN] && s_reg.gc0 && !reg_wr
                                 |=> $stable(s_reg.bits_left))  // RL7
    else $error("engine moved while powered down");
  a_dma_gate: assert property (!s_reg.ien[B_DMA] |=> !dma_tx_req && !dma_rx_req)  // RL11
    else $error("DMA request without enable");
  a_tx_irq_line: assert property (s_reg.flg[F_TX] && s_reg.ien[B_TX] && !s_reg.lvl[B_TX]
                                  |=> irq_line_zero)  // RL13
    else $error("transmit interrupt missing on line zero");
  a_line_idle: assert property ((s_reg.flg & to_src(s_reg.ien)) == '0
                                |=> !irq_line_zero && !irq_line_one)  // RL24
    else $error("interrupt line high with nothing pending");
  a_dat_clear: assert property (reg_wr && reg_addr == OFS_DAT && s_reg.phase == PH_SHIFT
                                && s_reg.bits_left > 4'h1 |=> !s_reg.flg[F_TX])  // RL18
    else $error("data write did not clear transmit-empty");
  a_vec_ovr_clear: assert property (reg_rd && reg_addr == OFS_VEC0
                                    && s_reg.phase == PH_IDLE |=> !s_reg.flg[F_OVR])  // RL21
    else $error("vector read did not clear overrun");
endmodule

/* verification/spcr_peer.sv */
`timescale 1ns/1ps
module spcr_peer #(
  parameter logic [7:0] RESP = 8'h96
) (
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [2:0] idx_reg = 3'h7;
  initial rx_byte = 8'h00;
  // Pointer restarts at select and steps on each falling clock
  always @(negedge cs_n) idx_reg = 3'h7;
  always @(negedge sclk) if (!cs_n) idx_reg = idx_reg - 3'h1;
  // Capture on the rising clock, MSB first
  always @(posedge sclk) if (!cs_n) rx_byte <= {rx_byte[6:0], mosi};
  // Deselected, show the inverse so stale data cannot pass as a match
  assign miso = cs_n ? ~RESP[idx_reg] : RESP[idx_reg];
endmodule

/* verification/tb_spcr_regs.sv */
`timescale 1ns/1ps
module tb_spcr_regs;
  import spcr_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic [6:0]  reg_addr = 7'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr   = 1'b0;
  logic        reg_rd   = 1'b0;
  logic [31:0] reg_rdata, d;
  logic        mo_o, mo_oe, mi_o, mi_oe, sc_o, sc_oe, txq, rxq, irq0, irq1, miso;
  logic [1:0]  cs_o, cs_oe;
  logic [7:0]  peer_rx;
  int          miscompares = 0;
  int          total_checks = 0;
  // Wire levels: pull-up on data out, clock idles low, selects pulled high
  wire         mo_w = mo_oe ? mo_o : 1'b1;
  wire         mi_w = mi_oe ? mi_o : miso;
  wire         sc_w = sc_oe ? sc_o : 1'b0;
  wire [1:0]   cs_w = cs_oe & cs_o | ~cs_oe;

  spcr_regs i_spcr_regs (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .master_out_pin_i(mo_w), .master_out_pin_o(mo_o), .master_out_pin_oe(mo_oe),
    .master_in_pin_i(mi_w), .master_in_pin_o(mi_o), .master_in_pin_oe(mi_oe),
    .serial_clock_pin_i(sc_w), .serial_clock_pin_o(sc_o), .serial_clock_pin_oe(sc_oe),
    .chip_select_pins_i(cs_w), .chip_select_pins_o(cs_o), .chip_select_pins_oe(cs_oe),
    .dma_tx_req(txq), .dma_rx_req(rxq), .irq_line_zero(irq0), .irq_line_one(irq1));
  spcr_peer i_spcr_peer (.sclk(sc_w), .cs_n(cs_w[0]), .mosi(mo_w), .miso(miso),
    .rx_byte(peer_rx));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic close_out();
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [6:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // A word takes 8 bits of 8 cycles plus its closing fall; 100 leaves margin
  task automatic word_time();
    repeat (100) @(posedge core_clk);
    // Step off the edge so outputs are settled when compared
    #1;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    rd(OFS_BUF);
    chk(d, 32'h8000_0000);
    wr(OFS_GC1, 32'h0000_0003);
    rd(OFS_GC1);
    chk(d, 32'h0000_0000);
    rd(7'h70);
    chk(d, 32'h0000_0000);
    wr(OFS_GC0, 32'h0000_0001);
    wr(OFS_PC0, PC0_MASK);
    wr(OFS_LVL, 32'h0000_0200);
    wr(OFS_INT, 32'h0001_0300);
    // Master with internal clock is settled before loop-back is chosen
    wr(OFS_GC1, 32'h0000_0003);
    wr(OFS_GC1, 32'h0001_0003);
    wr(OFS_GC1, 32'h0101_0003);
    rd(OFS_GC1);
    chk(d, 32'h0101_0003);
    chk({31'h0, irq1}, 32'h0000_0000);
    // Loop-back: second word waits, so the empty flag must drop
    wr(OFS_DAT, 32'h0000_00A5);
    wr(OFS_DAT, 32'h0000_005A);
    rd(OFS_FLG);
    chk(d, 32'h0000_0000);
    chk({30'h0, sc_o, mi_oe}, 32'h0000_0000);
    word_time();
    chk({28'h0, irq1, irq0, txq, rxq}, 32'h0000_000F);
    rd(OFS_BUF);
    chk(d & 32'h8000_FFFF, 32'h0000_00A5);
    word_time();
    wr(OFS_DAT, 32'h0000_0011);
    word_time();
    wr(OFS_DAT, 32'h0000_0022);
    word_time();
    rd(OFS_FLG);
    chk({31'h0, d[B_OVR]}, 32'h0000_0001);
    rd(OFS_VEC0);
    rd(OFS_FLG);
    chk({31'h0, d[B_OVR]}, 32'h0000_0000);
    // Disable clears flags and buffers
    wr(OFS_GC1, 32'h0001_0003);
    rd(OFS_FLG);
    chk(d, 32'h0000_0000);
    rd(OFS_BUF);
    chk(d, 32'h8000_0000);
    // Power-down: a written word must not start
    wr(OFS_GC1, 32'h0101_0103);
    wr(OFS_DAT, 32'h0000_0077);
    word_time();
    rd(OFS_FLG);
    chk(d, 32'h0000_0000);
    // Master, internal clock, talking to the peer
    wr(OFS_GC1, 32'h0000_0003);
    wr(OFS_DEF, 32'h0000_0003);
    wr(OFS_GC1, 32'h0100_0003);
    // Pin enables leave flops one cycle after the control write lands
    @(posedge core_clk);
    #1 chk({27'h0, sc_oe, mo_oe, mi_oe, cs_oe}, 32'h0000_001B);
    wr(OFS_DAT, 32'h0001_003C);
    word_time();
    rd(OFS_BUF);
    chk(d & 32'h0000_FFFF, 32'h0000_0096);
    chk({24'h0, peer_rx}, 32'h0000_003C);
    rd(OFS_FLG);
    chk({31'h0, d[B_BIT]}, 32'h0000_0000);
    // Slave role turns both data pins and the selects round
    wr(OFS_GC1, 32'h0000_0003);
    wr(OFS_GC1, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    #1 chk({26'h0, mi_o, sc_oe, mo_oe, mi_oe, cs_oe}, 32'h0000_0004);
    close_out();
  end
endmodule
